/* File: pkg/sar_pkg.sv */
// Register map, encodings, types and check-byte helper for the register access port
package sar_pkg;
  // Register indices; the printed offsets are the indices
  localparam logic [7:0] REG_DEVICE_IDENTITY   = 8'h00;
  localparam logic [7:0] REG_BOARD_REVISION    = 8'h01;
  localparam logic [7:0] REG_FW_MAJOR_VERSION  = 8'h02;
  localparam logic [7:0] REG_FW_MINOR_VERSION  = 8'h03;
  localparam logic [7:0] REG_UPDATE_RATE_HZ    = 8'h04;
  localparam logic [7:0] REG_ACCEL_FULL_SCALE  = 8'h05;
  localparam logic [7:0] REG_GYRO_FULL_SCALE_L = 8'h06;
  localparam logic [7:0] REG_GYRO_FULL_SCALE_H = 8'h07;
  localparam logic [7:0] REG_OPERATIONAL_STAT  = 8'h08;
  localparam logic [7:0] REG_CALIBRATION_STAT  = 8'h09;
  localparam logic [7:0] REG_SELFTEST_STAT     = 8'h0A;
  localparam logic [7:0] REG_CAPABILITY_LOW    = 8'h0B;
  localparam logic [7:0] REG_CAPABILITY_HIGH   = 8'h0C;
  localparam logic [7:0] REG_LAST              = 8'h0F;
  localparam logic [7:0] RESERVED_VALUE        = 8'h00;

  // Address and command byte layout
  localparam int unsigned RW_FLAG_BIT  = 7;
  localparam int unsigned BYTE_MSB     = 7;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [7:0]  CRC_POLY     = 8'h91;
  localparam logic [7:0]  CRC_SEED     = 8'h00;

  // Link rate limits and the derived least half-period of a link clock
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned I2C_MAX_HZ      = 400000;
  localparam int unsigned SPI_MAX_BPS     = 2000000;
  localparam int unsigned I2C_HALF_CYC    = CLK_HZ / (2 * I2C_MAX_HZ);
  localparam int unsigned SPI_HALF_CYC    = CLK_HZ / (2 * SPI_MAX_BPS);

  // Values that the sensor core supplies for the read-only registers
  typedef struct packed {
    logic [7:0]  boardRevision;
    logic [7:0]  fwMajorVersion;
    logic [7:0]  fwMinorVersion;
    logic [7:0]  accelFullScale;
    logic [15:0] gyroFullScale;
    logic [7:0]  operationalStatus;
    logic [7:0]  calibrationStatus;
    logic [7:0]  selftestStatus;
    logic [15:0] capabilityFlags;
  } sar_info_t;

  // One register write request
  typedef struct packed {
    logic       en;
    logic [7:0] idx;
    logic [7:0] data;
  } sar_wr_t;

  typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_MACK} sar_i2c_st_t;

  // One byte step of the 7-bit check code, shifting out the low bit
  function automatic logic [7:0] sarCrcByte(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = c ^ CRC_POLY;
      end
      c = {1'b0, c[7:1]};
    end
    return c;
  endfunction : sarCrcByte

  // Register read mux; every operand is an argument, so a continuous caller re-evaluates
  function automatic logic [7:0] sarRegRead(input sar_info_t info, input logic [7:0] rate,
                                            input logic [7:0] ident, input logic [7:0] idx);
    logic [7:0] v;
    v = RESERVED_VALUE;
    case (idx)
      REG_DEVICE_IDENTITY:   v = ident;
      REG_BOARD_REVISION:    v = info.boardRevision;
      REG_FW_MAJOR_VERSION:  v = info.fwMajorVersion;
      REG_FW_MINOR_VERSION:  v = info.fwMinorVersion;
      REG_UPDATE_RATE_HZ:    v = rate;
      REG_ACCEL_FULL_SCALE:  v = info.accelFullScale;
      REG_GYRO_FULL_SCALE_L: v = info.gyroFullScale[7:0];
      REG_GYRO_FULL_SCALE_H: v = info.gyroFullScale[15:8];
      REG_OPERATIONAL_STAT:  v = info.operationalStatus;
      REG_CALIBRATION_STAT:  v = info.calibrationStatus;
      REG_SELFTEST_STAT:     v = info.selftestStatus;
      REG_CAPABILITY_LOW:    v = info.capabilityFlags[7:0];
      REG_CAPABILITY_HIGH:   v = info.capabilityFlags[15:8];
      default:               v = RESERVED_VALUE;
    endcase
    return v;
  endfunction : sarRegRead
endpackage : sar_pkg

/* File: design/sar_register_access_port.sv */
// Slave register access port of a motion sensor, reached over I2C or SPI
// Functional notes
// - Answers I2C at one fixed 7-bit address; master keeps it unique.
// - I2C works at bus clocks up to 400 kHz.
// - I2C address byte with top bit set means write, clear means read.
// - I2C read returns successive registers until master stops or last passed.
// - SPI is MSB first, mode 3, at most 2 Mbit/s.
// - First SPI byte is register index; bit 0x80 set means write.
// - SPI write commits when chip select rises after the check byte.
// - Read phase returns count register bytes then a check byte.
// - Check byte is the 7-bit CRC with polynomial 0x91.
// - Multi-byte values least significant byte first, signed as two's complement.
// - Fixed-point values are scaled and rounded; Q16.16 takes four bytes.
module sar_register_access_port #(
  parameter logic [6:0] I2C_ADDR      = 7'h2A,  // Arbitrary value
  parameter logic [7:0] IDENTITY_CODE = 8'h5A,  // Arbitrary value
  parameter logic [7:0] UPDATE_RATE_RESET = 8'h3C
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Sensor core values
  input  wire sar_pkg::sar_info_t info,
  // I2C pins, SDA open drain
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe,
  // SPI pins
  input  wire logic              sclkIn,
  input  wire logic              spiCsN,
  input  wire logic              mosiIn,
  output logic                   misoOut,
  output logic                   misoOe,
  // Writable configuration
  output logic [7:0]             updateRateHz,
  output logic                   regWritePulse
);
  import sar_pkg::*;
  // Pin synchronisers: scl, sda, sclk, cs, mosi; reset to idle levels, so no false edge
  logic [4:0] pinMeta_q;
  logic [4:0] pinSync_q;
  logic [4:0] pinPrev_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinMeta_q <= 5'h1F;
      pinSync_q <= 5'h1F;
      pinPrev_q <= 5'h1F;
    end else begin
      // Sampling at 40 MHz leaves many cycles per half bit at both link limits
      pinMeta_q <= {mosiIn, spiCsN, sclkIn, sdaIn, sclIn};
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end
  logic scl, sda, sclk, csN, mosi;
  assign scl  = pinSync_q[0];
  assign sda  = pinSync_q[1];
  assign sclk = pinSync_q[2];
  assign csN  = pinSync_q[3];
  assign mosi = pinSync_q[4];
  logic sclRise, sclFall, i2cStart, i2cStop, sclkRise, sclkFall, csFall, csRise;
  assign sclRise  = scl & ~pinPrev_q[0];
  assign sclFall  = ~scl & pinPrev_q[0];
  assign i2cStart = scl & pinPrev_q[0] & ~sda & pinPrev_q[1];
  assign i2cStop  = scl & pinPrev_q[0] & sda & ~pinPrev_q[1];
  assign sclkRise = sclk & ~pinPrev_q[2];
  assign sclkFall = ~sclk & pinPrev_q[2];
  assign csFall   = ~csN & pinPrev_q[3];
  assign csRise   = csN & ~pinPrev_q[3];
  logic [7:0] updateRate_q;
  // I2C slave
  sar_i2c_st_t i2cState_q;
  logic [7:0]  i2cSr_q;
  logic [7:0]  i2cTx_q;
  logic [3:0]  i2cCnt_q;
  logic [1:0]  i2cByteIdx_q;
  logic        i2cWriteDir_q;
  logic        i2cNack_q;
  logic [7:0]  i2cPtr_q;
  logic        sdaOe_q;
  sar_wr_t     i2cWr_q;
  logic [7:0]  i2cNextByte;
  // Byte to load: index itself on the first data byte, else the next; low byte first
  assign i2cNextByte = sarRegRead(info, updateRate_q, IDENTITY_CODE,
                                  (i2cState_q == I2C_ACK) ? i2cPtr_q : i2cPtr_q + 8'h01);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      i2cState_q    <= I2C_IDLE;
      i2cSr_q       <= 8'h00;
      i2cTx_q       <= 8'h00;
      i2cCnt_q      <= 4'h0;
      i2cByteIdx_q  <= 2'h0;
      i2cWriteDir_q <= 1'b0;
      i2cNack_q     <= 1'b0;
      i2cPtr_q      <= 8'h00;
      sdaOe_q       <= 1'b0;
      i2cWr_q       <= '0;
    end else begin
      i2cWr_q.en <= 1'b0;
      if (i2cStop) begin
        i2cState_q <= I2C_IDLE;
        sdaOe_q    <= 1'b0;
      end else if (i2cStart) begin
        // Repeated start keeps the pointer for a read after an index write
        i2cState_q   <= I2C_RX;
        i2cCnt_q     <= 4'h0;
        i2cByteIdx_q <= 2'h0;
        sdaOe_q      <= 1'b0;
      end else begin
        case (i2cState_q)
          I2C_RX: begin
            if (sclRise) begin
              i2cSr_q  <= {i2cSr_q[6:0], sda};
              i2cCnt_q <= i2cCnt_q + 4'h1;
            end else if (sclFall && i2cCnt_q == BITS_PER_BYTE) begin
              i2cCnt_q   <= 4'h0;
              i2cState_q <= I2C_ACK;
              sdaOe_q    <= 1'b1;
              i2cByteIdx_q <= i2cByteIdx_q + {1'b0, i2cByteIdx_q != 2'h2};
              case (i2cByteIdx_q)
                2'h0: begin
                  if (i2cSr_q[6:0] == I2C_ADDR) begin
                    i2cWriteDir_q <= i2cSr_q[RW_FLAG_BIT];
                  end else begin
                    i2cState_q <= I2C_IDLE;
                    sdaOe_q    <= 1'b0;
                  end
                end
                2'h1: i2cPtr_q <= i2cSr_q;
                default: begin
                  i2cWr_q.en   <= 1'b1;
                  i2cWr_q.idx  <= i2cPtr_q;
                  i2cWr_q.data <= i2cSr_q;
                  i2cPtr_q     <= i2cPtr_q + 8'h01;
                end
              endcase
            end
          end
          I2C_ACK: begin
            if (sclFall) begin
              if (i2cByteIdx_q == 2'h1 && !i2cWriteDir_q) begin
                i2cTx_q    <= {i2cNextByte[6:0], 1'b0};
                sdaOe_q    <= ~i2cNextByte[BYTE_MSB];
                i2cCnt_q   <= 4'h1;
                i2cState_q <= I2C_TX;
              end else begin
                sdaOe_q    <= 1'b0;
                i2cState_q <= I2C_RX;
              end
            end
          end
          I2C_TX: begin
            if (sclFall) begin
              if (i2cCnt_q == BITS_PER_BYTE) begin
                sdaOe_q    <= 1'b0;
                i2cCnt_q   <= 4'h0;
                i2cState_q <= I2C_MACK;
              end else begin
                sdaOe_q  <= ~i2cTx_q[BYTE_MSB];
                i2cTx_q  <= {i2cTx_q[6:0], 1'b0};
                i2cCnt_q <= i2cCnt_q + 4'h1;
              end
            end
          end
          I2C_MACK: begin
            if (sclRise) begin
              i2cNack_q <= sda;
            end else if (sclFall) begin
              // Burst ends on master NACK or once the last register went out
              if (i2cNack_q || i2cPtr_q >= REG_LAST) begin
                i2cState_q <= I2C_IDLE;
              end else begin
                i2cPtr_q   <= i2cPtr_q + 8'h01;
                i2cTx_q    <= {i2cNextByte[6:0], 1'b0};
                sdaOe_q    <= ~i2cNextByte[BYTE_MSB];
                i2cCnt_q   <= 4'h1;
                i2cState_q <= I2C_TX;
              end
            end
          end
          default: sdaOe_q <= 1'b0;
        endcase
      end
    end
  end

  // SPI slave
  logic [7:0] spiSr_q;
  logic [2:0] spiBit_q;
  logic [1:0] spiByteCnt_q;
  logic [7:0] spiIdx_q;
  logic [7:0] spiVal_q;
  logic [7:0] spiCrc_q;
  logic       spiCmdOk_q;
  logic       spiArmed_q;
  logic       spiDataPhase_q;
  logic [7:0] spiStart_q;
  logic [7:0] spiCount_q;
  logic [7:0] spiPtr_q;
  logic [7:0] spiLeft_q;
  logic       spiCrcSent_q;
  logic [7:0] spiTx_q;
  logic       miso_q;
  sar_wr_t    spiWr_q;
  logic [7:0] spiRxByte;
  logic [7:0] spiRegByte;
  assign spiRxByte  = {spiSr_q[6:0], mosi};
  assign spiRegByte = sarRegRead(info, updateRate_q, IDENTITY_CODE, spiPtr_q);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spiSr_q        <= 8'h00;
      spiBit_q       <= 3'h0;
      spiByteCnt_q   <= 2'h0;
      spiIdx_q       <= 8'h00;
      spiVal_q       <= 8'h00;
      spiCrc_q       <= CRC_SEED;
      spiCmdOk_q     <= 1'b0;
      spiArmed_q     <= 1'b0;
      spiDataPhase_q <= 1'b0;
      spiStart_q     <= 8'h00;
      spiCount_q     <= 8'h00;
      spiPtr_q       <= 8'h00;
      spiLeft_q      <= 8'h00;
      spiCrcSent_q   <= 1'b0;
      spiTx_q        <= 8'h00;
      miso_q         <= 1'b0;
      spiWr_q        <= '0;
    end else begin
      spiWr_q.en <= 1'b0;
      if (csFall) begin
        spiBit_q       <= 3'h0;
        spiByteCnt_q   <= 2'h0;
        spiCmdOk_q     <= 1'b0;
        spiCrc_q       <= CRC_SEED;
        spiDataPhase_q <= spiArmed_q;
        spiArmed_q     <= 1'b0;
        spiPtr_q       <= spiStart_q;
        spiLeft_q      <= spiCount_q;
        spiCrcSent_q   <= 1'b0;
      end else if (csRise) begin
        spiDataPhase_q <= 1'b0;
        // Only a complete command with a matching check byte acts
        if (!spiDataPhase_q && spiCmdOk_q && spiByteCnt_q == 2'h3) begin
          if (spiIdx_q[RW_FLAG_BIT]) begin
            spiWr_q.en   <= 1'b1;
            spiWr_q.idx  <= {1'b0, spiIdx_q[6:0]};
            spiWr_q.data <= spiVal_q;
          end else begin
            // Data is read live at the next phase, so no preparation wait is needed
            spiArmed_q <= 1'b1;
            spiStart_q <= spiIdx_q;
            spiCount_q <= spiVal_q;
          end
        end
      end else if (!csN) begin
        if (sclkRise) begin
          spiSr_q  <= spiRxByte;
          spiBit_q <= spiBit_q + 3'h1;
          if (spiBit_q == 3'h7 && !spiDataPhase_q) begin
            spiByteCnt_q <= spiByteCnt_q + {1'b0, spiByteCnt_q != 2'h3};
            case (spiByteCnt_q)
              2'h0: begin
                spiIdx_q <= spiRxByte;
                spiCrc_q <= sarCrcByte(spiCrc_q, spiRxByte);
              end
              2'h1: begin
                spiVal_q <= spiRxByte;
                spiCrc_q <= sarCrcByte(spiCrc_q, spiRxByte);
              end
              2'h2: spiCmdOk_q <= (spiRxByte == spiCrc_q);
              default: spiCmdOk_q <= 1'b0;
            endcase
          end
        end else if (sclkFall && spiDataPhase_q) begin
          // Mode 3 drives each bit on the falling edge
          if (spiBit_q == 3'h0) begin
            if (spiLeft_q != 8'h00) begin
              miso_q    <= spiRegByte[BYTE_MSB];
              spiTx_q   <= {spiRegByte[6:0], 1'b0};
              spiCrc_q  <= sarCrcByte(spiCrc_q, spiRegByte);
              spiPtr_q  <= spiPtr_q + 8'h01;
              spiLeft_q <= spiLeft_q - 8'h01;
            end else begin
              miso_q       <= spiCrcSent_q ? 1'b0 : spiCrc_q[BYTE_MSB];
              spiTx_q      <= spiCrcSent_q ? 8'h00 : {spiCrc_q[6:0], 1'b0};
              spiCrcSent_q <= 1'b1;
            end
          end else begin
            miso_q  <= spiTx_q[BYTE_MSB];
            spiTx_q <= {spiTx_q[6:0], 1'b0};
          end
        end
      end
    end
  end
  // Writable register; other indices are read-only and writes to them drop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      updateRate_q  <= UPDATE_RATE_RESET;
      regWritePulse <= 1'b0;
    end else begin
      regWritePulse <= 1'b0;
      if (i2cWr_q.en && i2cWr_q.idx == REG_UPDATE_RATE_HZ) begin
        updateRate_q  <= i2cWr_q.data;
        regWritePulse <= 1'b1;
      end else if (spiWr_q.en && spiWr_q.idx == REG_UPDATE_RATE_HZ) begin
        updateRate_q  <= spiWr_q.data;
        regWritePulse <= 1'b1;
      end
    end
  end
  // Output flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdaOut  <= 1'b0;
      sdaOe   <= 1'b0;
      misoOut <= 1'b0;
      misoOe  <= 1'b0;
    end else begin
      sdaOut  <= 1'b0;
      sdaOe   <= sdaOe_q;
      misoOut <= miso_q;
      misoOe  <= spiDataPhase_q & ~csN;
    end
  end
  assign updateRateHz = updateRate_q;
  // Fixed-point scaling is done by the sensor core; this port passes bytes unchanged
endmodule : sar_register_access_port

/* File: verification/sar_port_sva.sv */
// Concurrent checks on the outputs of the register access port
module sar_port_sva #(
  parameter logic [7:0] UPDATE_RATE_RESET = 8'h3C
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Link pins
  input wire logic       sclIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       sclkIn,
  input wire logic       spiCsN,
  input wire logic       misoOut,
  input wire logic       misoOe,
  // Configuration
  input wire logic [7:0] updateRateHz,
  input wire logic       regWritePulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rst_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !sdaOe && !misoOe && !regWritePulse && updateRateHz == UPDATE_RATE_RESET)
    else $error("outputs not quiet after reset");
  a_pulse_single: assert property (
    regWritePulse |=> !regWritePulse) else $error("write pulse longer than one cycle");
  a_rate_cause: assert property (
    !$stable(updateRateHz) |-> $past(regWritePulse) or ##[0:1] regWritePulse)
    else $error("update rate changed without a write");
  a_sda_open: assert property (
    sdaOe |-> !sdaOut) else $error("SDA driven high");
  a_sda_timing: assert property (
    $changed(sdaOe) |-> !sclIn && $past(!sclIn, 3)) else $error("SDA moved while SCL high");
  a_miso_quiet: assert property (
    spiCsN [*8] |-> !misoOe) else $error("MISO driven while deselected");
  a_miso_start: assert property (
    $rose(misoOe) |-> !spiCsN && $past(!spiCsN, 2)) else $error("MISO driven early");
  a_miso_timing: assert property (
    misoOe && $past(misoOe) && !spiCsN && $changed(misoOut) |-> $past(!sclkIn, 3))
    else $error("MISO changed outside SCLK low");
endmodule : sar_port_sva

/* File: verification/sar_master_model.sv */
// Bus master model driving the I2C and SPI pins of the access port
module sar_master_model #(
  parameter int SPI_HALF = sar_pkg::SPI_HALF_CYC,
  parameter int I2C_HALF = sar_pkg::I2C_HALF_CYC
) (
  // Clock for pacing
  input wire logic clk,
  // I2C pins
  output logic     sclIn,
  output logic     sdaIn,
  input wire logic sdaOe,
  // SPI pins
  output logic     sclkIn,
  output logic     spiCsN,
  output logic     mosiIn,
  input wire logic misoOut,
  input wire logic misoOe
);
  timeunit 1ns;
  timeprecision 1ps;
  import sar_pkg::*;
  logic mstLow;
  logic lastMiso;
  logic misoWire;

  // Pull-up on SDA, either side may pull it low
  assign sdaIn = !(mstLow || sdaOe);
  // A released MISO shows the inverse of its last level, not a stale copy
  always @(posedge clk) if (misoOe) lastMiso <= misoOut;
  assign misoWire = misoOe ? misoOut : ~lastMiso;

  initial begin
    sclIn = 1'b1;
    mstLow = 1'b0;
    sclkIn = 1'b1;
    spiCsN = 1'b1;
    mosiIn = 1'b1;
    lastMiso = 1'b0;
  end

  task automatic waitClk(input int n);
    repeat (n) @(negedge clk);
  endtask : waitClk

  task automatic spiCs(input logic lvl);
    waitClk(SPI_HALF);
    spiCsN = lvl;
    waitClk(SPI_HALF);
  endtask : spiCs

  // Mode 3, MSB first: drive after SCLK falls, sample as it rises
  task automatic spiByte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = BYTE_MSB; i >= 0; i--) begin
      sclkIn = 1'b0;
      mosiIn = tx[i];
      waitClk(SPI_HALF);
      sclkIn = 1'b1;
      rx[i] = misoWire;
      waitClk(SPI_HALF);
    end
  endtask : spiByte

  // Also serves as repeated start when SCL is low
  task automatic i2cStart();
    waitClk(5);
    mstLow = 1'b0;
    waitClk(I2C_HALF);
    sclIn = 1'b1;
    waitClk(I2C_HALF);
    mstLow = 1'b1;
    waitClk(I2C_HALF);
    sclIn = 1'b0;
  endtask : i2cStart

  task automatic i2cStop();
    waitClk(5);
    mstLow = 1'b1;
    waitClk(I2C_HALF);
    sclIn = 1'b1;
    waitClk(I2C_HALF);
    mstLow = 1'b0;
    waitClk(I2C_HALF);
  endtask : i2cStop

  // SDA held a few cycles past SCL fall so no false start or stop is seen
  task automatic i2cBit(input logic b, output logic r);
    waitClk(5);
    mstLow = !b;
    waitClk(I2C_HALF);
    sclIn = 1'b1;
    waitClk(I2C_HALF);
    r = sdaIn;
    sclIn = 1'b0;
  endtask : i2cBit

  task automatic i2cByte(input logic [7:0] tx, input logic nth, output logic [7:0] rx,
                         output logic nthIn);
    for (int i = BYTE_MSB; i >= 0; i--) i2cBit(tx[i], rx[i]);
    i2cBit(nth, nthIn);
  endtask : i2cByte
endmodule : sar_master_model

/* File: verification/test_sensor_register_access_port.sv */
// Self-checking bench for the sensor register access port
module test_sensor_register_access_port;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_pkg::*;
  localparam logic [7:0] ID_CODE  = 8'h6B;  // Arbitrary value
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  sar_info_t  info = {8'h11, 8'h22, 8'h33, 8'h44, 16'h07D0, 8'h66, 8'h77, 8'h88, 16'hC3A5};
  logic       sclIn, sdaIn, sdaOut, sdaOe, sclkIn, spiCsN, mosiIn, misoOut, misoOe;
  logic [7:0] updateRateHz;
  logic       regWritePulse;
  logic [7:0] expRate = 8'h3C;
  int         badCount = 0;
  int         cmpCount = 0;
  int         pulseCnt = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) if (regWritePulse === 1'b1) pulseCnt++;

  sar_register_access_port #(.I2C_ADDR(DEV_ADDR), .IDENTITY_CODE(ID_CODE))
  sar_register_access_port_inst (.clk(clk), .rst_n(rst_n), .info(info), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclkIn(sclkIn), .spiCsN(spiCsN),
    .mosiIn(mosiIn), .misoOut(misoOut), .misoOe(misoOe), .updateRateHz(updateRateHz),
    .regWritePulse(regWritePulse));
  sar_master_model sar_master_model_inst (.clk(clk), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOe(sdaOe), .sclkIn(sclkIn), .spiCsN(spiCsN), .mosiIn(mosiIn), .misoOut(misoOut),
    .misoOe(misoOe));

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) c = (c ^ (c[0] ? CRC_POLY : 8'h00)) >> 1;
    return c;
  endfunction : crc8

  function automatic logic [7:0] expReg(input logic [7:0] idx);
    case (idx)
      REG_DEVICE_IDENTITY:   return ID_CODE;
      REG_BOARD_REVISION:    return info.boardRevision;
      REG_FW_MAJOR_VERSION:  return info.fwMajorVersion;
      REG_FW_MINOR_VERSION:  return info.fwMinorVersion;
      REG_UPDATE_RATE_HZ:    return expRate;
      REG_ACCEL_FULL_SCALE:  return info.accelFullScale;
      REG_GYRO_FULL_SCALE_L: return info.gyroFullScale[7:0];
      REG_GYRO_FULL_SCALE_H: return info.gyroFullScale[15:8];
      REG_OPERATIONAL_STAT:  return info.operationalStatus;
      REG_CALIBRATION_STAT:  return info.calibrationStatus;
      REG_SELFTEST_STAT:     return info.selftestStatus;
      REG_CAPABILITY_LOW:    return info.capabilityFlags[7:0];
      REG_CAPABILITY_HIGH:   return info.capabilityFlags[15:8];
      default:               return RESERVED_VALUE;
    endcase
  endfunction : expReg

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : printVerdict

  // Flip corrupts the check byte
  task automatic spiCmd(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] flip);
    logic [7:0] rx;
    sar_master_model_inst.spiCs(1'b0);
    sar_master_model_inst.spiByte(b0, rx);
    sar_master_model_inst.spiByte(b1, rx);
    sar_master_model_inst.spiByte(crc8(crc8(CRC_SEED, b0), b1) ^ flip, rx);
    sar_master_model_inst.spiCs(1'b1);
    repeat (20) @(negedge clk);
  endtask : spiCmd

  task automatic spiRead(input logic [7:0] idx, input logic [7:0] cnt);
    logic [7:0] rx;
    logic [7:0] crc;
    spiCmd(idx, cnt, 8'h00);
    crc = CRC_SEED;
    repeat (8000) @(negedge clk);
    sar_master_model_inst.spiCs(1'b0);
    for (int k = 0; k <= cnt; k++) begin
      sar_master_model_inst.spiByte(8'h00, rx);
      if (k < cnt) begin
        chk("spi read data", rx, expReg(idx + 8'(k)));
        crc = crc8(crc, expReg(idx + 8'(k)));
      end else begin
        chk("spi read check byte", rx, crc);
      end
    end
    sar_master_model_inst.spiCs(1'b1);
  endtask : spiRead

  task automatic i2cSend(input logic [7:0] b, input logic nack);
    logic [7:0] rx;
    logic       ack;
    sar_master_model_inst.i2cByte(b, 1'b1, rx, ack);
    chk("i2c acknowledge", {7'h00, ack}, {7'h00, nack});
  endtask : i2cSend

  // Past the last register the device lets SDA float to the pull-up
  task automatic i2cRead(input logic [7:0] idx, input int n);
    logic [7:0] rx;
    logic       ack;
    sar_master_model_inst.i2cStart();
    i2cSend({1'b1, DEV_ADDR}, 1'b0);
    i2cSend(idx, 1'b0);
    sar_master_model_inst.i2cStart();
    i2cSend({1'b0, DEV_ADDR}, 1'b0);
    for (int k = 0; k < n; k++) begin
      sar_master_model_inst.i2cByte(8'hFF, k == n - 1, rx, ack);
      chk("i2c read data", rx, (idx + k > REG_LAST) ? 8'hFF : expReg(idx + 8'(k)));
    end
    sar_master_model_inst.i2cStop();
  endtask : i2cRead

  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    spiCmd({1'b1, REG_UPDATE_RATE_HZ[6:0]}, 8'h20, 8'h00);
    expRate = 8'h20;
    chk("rate after spi write", updateRateHz, expRate);
    spiCmd(8'h84, 8'h55, 8'h01);
    spiCmd(8'h80, 8'hEE, 8'h00);
    chk("rate after refused writes", updateRateHz, expRate);
    chk("write pulses", 8'(pulseCnt), 8'h01);
    spiRead(REG_DEVICE_IDENTITY, REG_LAST - REG_DEVICE_IDENTITY);
    $display("test spi done");
    sar_master_model_inst.i2cStart();
    i2cSend({1'b1, DEV_ADDR}, 1'b0);
    i2cSend(REG_UPDATE_RATE_HZ, 1'b0);
    i2cSend(8'h11, 1'b0);
    sar_master_model_inst.i2cStop();
    expRate = 8'h11;
    repeat (20) @(negedge clk);
    chk("rate after i2c write", updateRateHz, expRate);
    sar_master_model_inst.i2cStart();
    i2cSend({1'b1, DEV_ADDR ^ 7'h01}, 1'b1);
    sar_master_model_inst.i2cStop();
    i2cRead(REG_UPDATE_RATE_HZ, 9);
    i2cRead(REG_LAST, 2);
    $display("test i2c done");
    printVerdict();
  end

  initial begin
    #1500000;
    badCount++;
    $display("watchdog expired");
    printVerdict();
  end
endmodule : test_sensor_register_access_port

bind sar_register_access_port sar_port_sva #(.UPDATE_RATE_RESET(UPDATE_RATE_RESET))
  sar_port_sva_inst (.clk(clk), .rst_n(rst_n), .sclIn(sclIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .sclkIn(sclkIn), .spiCsN(spiCsN), .misoOut(misoOut), .misoOe(misoOe),
  .updateRateHz(updateRateHz), .regWritePulse(regWritePulse));
